// [design/vcgr_pkg.sv]
// Constants for the vendor configuration and pin port register bank.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package vcgr_pkg;
  localparam logic [7:0] VCGR_OFS_ACK_LAT   = 8'hB0;
  localparam logic [7:0] VCGR_OFS_DRV_MODE  = 8'hB4;
  localparam logic [7:0] VCGR_OFS_PWR_PARAM = 8'hB8;
  localparam logic [7:0] VCGR_OFS_TEST_ONE  = 8'hBC;
  localparam logic [7:0] VCGR_OFS_TEST_TWO  = 8'hC0;
  localparam logic [7:0] VCGR_OFS_TEST_THR  = 8'hC4;
  localparam logic [7:0] VCGR_OFS_STRAP     = 8'hC8;
  localparam logic [7:0] VCGR_OFS_PIN_CTL   = 8'hD8;

  localparam int VCGR_LAT_LSB     = 16;
  localparam int VCGR_LAT_MSB     = 29;
  localparam int VCGR_LAT_EN_BIT  = 30;
  localparam int VCGR_PWR_MSB     = 5;
  localparam int VCGR_PIN_IN_LSB  = 0;
  localparam int VCGR_PIN_DIR_LSB = 8;
  localparam int VCGR_PIN_OUT_LSB = 16;
  localparam int VCGR_PIN_COUNT   = 8;

  localparam logic [13:0] VCGR_LAT_RESET     = 14'h0000;
  localparam logic        VCGR_LAT_EN_RESET  = 1'b0;
  localparam logic [31:0] VCGR_DRV_RESET     = 32'h0000_0000;
  localparam logic [5:0]  VCGR_PWR_RESET     = 6'h00;
  localparam logic [31:0] VCGR_TEST_RESET    = 32'h0000_0000;
  localparam logic [7:0]  VCGR_PIN_RESET     = 8'h00;

  localparam logic [3:0] VCGR_MODE_RS232    = 4'h0;
  localparam logic [3:0] VCGR_MODE_RS422    = 4'h1;
  localparam logic [3:0] VCGR_MODE_RS485_4W = 4'hB;
  localparam logic [3:0] VCGR_MODE_RS485_2W = 4'hF;
endpackage

// [design/vcgr_sync3.sv]
// Three-stage synchroniser for an asynchronous input bus.
// Output changes only once the second and third stages agree.
`timescale 1ns/1ps
module vcgr_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= (agree & stage3) | (~agree & sync_out);
    end
  end
endmodule

// [design/vcgr_regs.sv]
// Vendor configuration register bank with strap copies and an eight-pin port.
// Assumes a plain strobe bus on sys_clk and a nonvolatile loader that pulses
// load_valid with full words after reset.
//
// Notes on behaviour
// - Bits 29:16 of the latency word hold a 14-bit user latency, reset to zero.
// - Bit 30 enables the user latency in place of the built-in default, reset to zero.
// - After reset the loader may overwrite latency, driver, power and strap fields.
// - A driver code of 0, 1, B or F hex selects RS232, RS422, four-wire or two-wire RS485.
// - Driver fields sit at 3:0, 7:4, 11:8 and 31:28, with 27:12 kept as writable storage.
// - The three test words read zero and ignore writes.
// - Strap word bits 0 and 1 show the low and high drive current straps.
// - Strap word bits 5:2 show transmit current straps and 9:6 de-emphasis straps.
// - Bits 11:10 and 13:12 show termination straps, and bits 31:14 read zero.
// - Pin word bits 7:0 read the present pin levels.
// - Pin word bits 15:8 set direction, one meaning output.
// - Pins are driven from bits 23:16 only while their direction bit is one; 31:24 reserved.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module vcgr_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        load_valid,
  input  wire logic [7:0]  load_addr,
  input  wire logic [31:0] load_data,
  input  wire logic        low_drive_strap,
  input  wire logic        high_drive_strap,
  input  wire logic [3:0]  tx_current_straps,
  input  wire logic [3:0]  deemphasis_straps,
  input  wire logic [1:0]  rx_termination_straps,
  input  wire logic [1:0]  tx_termination_straps,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [13:0] ack_latency_value,
  output logic             ack_latency_user_en,
  output logic      [3:0]  port0_driver_mode,
  output logic      [3:0]  port1_driver_mode,
  output logic      [3:0]  port2_driver_mode,
  output logic      [3:0]  port3_driver_mode,
  output logic      [5:0]  power_parameter_value
);
  logic [13:0] user_latency;
  logic        user_latency_en;
  logic [31:0] serial_driver_mode;
  logic [5:0]  power_parameter;
  logic [13:0] strap_value;
  logic        strap_loaded;
  logic [7:0]  pin_dir;
  logic [7:0]  pin_drive;

  // Straps and pins come from outside the clock domain
  wire  [13:0] strap_raw = {tx_termination_straps, rx_termination_straps, deemphasis_straps,
                            tx_current_straps, high_drive_strap, low_drive_strap};
  logic [13:0] strap_sync;
  logic [7:0]  pin_sync;

  vcgr_sync3 #(.WIDTH(14)) u_strap_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (strap_raw),
    .sync_out (strap_sync)
  );

  vcgr_sync3 #(.WIDTH(8)) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  wire wr_lat   = reg_wr && reg_addr == vcgr_pkg::VCGR_OFS_ACK_LAT;
  wire wr_drv   = reg_wr && reg_addr == vcgr_pkg::VCGR_OFS_DRV_MODE;
  wire wr_pwr   = reg_wr && reg_addr == vcgr_pkg::VCGR_OFS_PWR_PARAM;
  wire wr_pin   = reg_wr && reg_addr == vcgr_pkg::VCGR_OFS_PIN_CTL;
  wire ld_lat   = load_valid && load_addr == vcgr_pkg::VCGR_OFS_ACK_LAT;
  wire ld_drv   = load_valid && load_addr == vcgr_pkg::VCGR_OFS_DRV_MODE;
  wire ld_pwr   = load_valid && load_addr == vcgr_pkg::VCGR_OFS_PWR_PARAM;
  wire ld_strap = load_valid && load_addr == vcgr_pkg::VCGR_OFS_STRAP;

  // Software write wins over a loader word landing in the same cycle
  wire [31:0] lat_src = wr_lat ? reg_wdata : load_data;
  wire [31:0] drv_src = wr_drv ? reg_wdata : load_data;
  wire [31:0] pwr_src = wr_pwr ? reg_wdata : load_data;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      user_latency    <= vcgr_pkg::VCGR_LAT_RESET;
      user_latency_en <= vcgr_pkg::VCGR_LAT_EN_RESET;
    end
    else if (wr_lat || ld_lat)
    begin
      user_latency    <= lat_src[vcgr_pkg::VCGR_LAT_MSB:vcgr_pkg::VCGR_LAT_LSB];
      user_latency_en <= lat_src[vcgr_pkg::VCGR_LAT_EN_BIT];
    end
  end

  // Reserved bits 27:12 share the word, so one register keeps them with the fields
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      serial_driver_mode <= vcgr_pkg::VCGR_DRV_RESET;
    else if (wr_drv || ld_drv)
      serial_driver_mode <= drv_src;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      power_parameter <= vcgr_pkg::VCGR_PWR_RESET;
    else if (wr_pwr || ld_pwr)
      power_parameter <= pwr_src[vcgr_pkg::VCGR_PWR_MSB:0];
  end

  // A loaded strap word replaces the pin copy until the next reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      strap_loaded <= 1'b0;
      strap_value  <= 14'h0000;
    end
    else if (ld_strap)
    begin
      strap_loaded <= 1'b1;
      strap_value  <= load_data[13:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_dir   <= vcgr_pkg::VCGR_PIN_RESET;
      pin_drive <= vcgr_pkg::VCGR_PIN_RESET;
    end
    else if (wr_pin)
    begin
      pin_dir   <= reg_wdata[vcgr_pkg::VCGR_PIN_DIR_LSB +: vcgr_pkg::VCGR_PIN_COUNT];
      pin_drive <= reg_wdata[vcgr_pkg::VCGR_PIN_OUT_LSB +: vcgr_pkg::VCGR_PIN_COUNT];
    end
  end

  // Output pins driven from flops; enable low leaves the pin floating
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;
    end
    else
    begin
      pin_out <= pin_drive & pin_dir;
      pin_oe  <= pin_dir;
    end
  end

  wire [13:0] strap_view = strap_loaded ? strap_value : strap_sync;
  wire [31:0] lat_word   = {1'b0, user_latency_en, user_latency, 16'h0000};
  wire [31:0] pwr_word   = {26'h0, power_parameter};
  wire [31:0] strap_word = {18'h0, strap_view};
  wire [31:0] pin_word   = {8'h00, pin_drive, pin_dir, pin_sync};

  // One-hot read selects; an unmapped offset selects nothing and reads zero
  wire sel_lat   = reg_addr == vcgr_pkg::VCGR_OFS_ACK_LAT;
  wire sel_drv   = reg_addr == vcgr_pkg::VCGR_OFS_DRV_MODE;
  wire sel_pwr   = reg_addr == vcgr_pkg::VCGR_OFS_PWR_PARAM;
  wire sel_test  = reg_addr == vcgr_pkg::VCGR_OFS_TEST_ONE ||
                   reg_addr == vcgr_pkg::VCGR_OFS_TEST_TWO ||
                   reg_addr == vcgr_pkg::VCGR_OFS_TEST_THR;
  wire sel_strap = reg_addr == vcgr_pkg::VCGR_OFS_STRAP;
  wire sel_pin   = reg_addr == vcgr_pkg::VCGR_OFS_PIN_CTL;

  wire [31:0] next_rdata = ({32{sel_lat}}   & lat_word)
                         | ({32{sel_drv}}   & serial_driver_mode)
                         | ({32{sel_pwr}}   & pwr_word)
                         | ({32{sel_test}}  & vcgr_pkg::VCGR_TEST_RESET)
                         | ({32{sel_strap}} & strap_word)
                         | ({32{sel_pin}}   & pin_word);

  // Read data valid only the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h0000_0000;
  end

  // Latency value stays programmed even while the enable is low
  assign ack_latency_value   = user_latency;
  assign ack_latency_user_en = user_latency_en;
  // Codes outside the four documented ones are stored and passed on untouched
  assign port0_driver_mode   = serial_driver_mode[3:0];
  assign port1_driver_mode   = serial_driver_mode[7:4];
  assign port2_driver_mode   = serial_driver_mode[11:8];
  assign port3_driver_mode   = serial_driver_mode[31:28];
  assign power_parameter_value = power_parameter;
endmodule

// [bench/vcgr_regs_checker.sv]
// Port-level assertions for the configuration and pin port register bank.
// Assumes one clock domain, sys_clk, with rst synchronous and active high.
`timescale 1ns/1ps
module vcgr_regs_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        load_valid,
  input wire logic [7:0]  load_addr,
  input wire logic [31:0] load_data,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [13:0] ack_latency_value,
  input wire logic        ack_latency_user_en,
  input wire logic [3:0]  port0_driver_mode,
  input wire logic [3:0]  port1_driver_mode,
  input wire logic [3:0]  port2_driver_mode,
  input wire logic [3:0]  port3_driver_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
  chk_test_words_zero: assert property (reg_rd && reg_addr inside {8'hBC, 8'hC0, 8'hC4} |=>
    reg_rdata == 32'h0000_0000) else $error("test word read not zero");
  chk_dir_follows_write: assert property (reg_wr && reg_addr == 8'hD8 |->
    ##2 pin_oe == $past(reg_wdata[15:8], 2)) else $error("pin direction not taken from write");
  chk_out_gated_dir: assert property ((pin_out & ~pin_oe) == 8'h00)
    else $error("pin level driven while direction is input");
  chk_latency_write: assert property (reg_wr && reg_addr == 8'hB0 |=>
    {ack_latency_user_en, ack_latency_value} == $past(reg_wdata[30:16])) else $error("latency fields wrong");
  chk_driver_write: assert property (reg_wr && reg_addr == 8'hB4 |=>
    {port3_driver_mode, port2_driver_mode, port1_driver_mode, port0_driver_mode}
    == {$past(reg_wdata[31:28]), $past(reg_wdata[11:0])}) else $error("driver fields wrong");
  chk_loader_driver: assert property (load_valid && load_addr == 8'hB4 && !(reg_wr && reg_addr == 8'hB4)
    |=> port0_driver_mode == $past(load_data[3:0])) else $error("loaded driver word not taken");
  chk_reset_rs232: assert property ($past(rst) |-> reg_rdata == 32'h0000_0000
    && {port3_driver_mode, port2_driver_mode, port1_driver_mode, port0_driver_mode} == 16'h0000)
    else $error("driver fields not RS232 after reset");
endmodule

bind vcgr_regs vcgr_regs_checker chk_i (.*);

// [bench/vendor_config_gpio_regs_tb.sv]
// Self-checking bench for the register bank, driving the strobe bus, loader, straps and pins.
// Assumes the checker is bound separately; the pad is not modelled, pin_in is driven directly.
`timescale 1ns/1ps
module vendor_config_gpio_regs_tb;
  logic        sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, load_valid = 1'b0;
  logic        low_drive_strap = 1'b0, high_drive_strap = 1'b0, ack_latency_user_en;
  logic [7:0]  reg_addr = 8'h00, load_addr = 8'h00, pin_in = 8'h00, pin_out, pin_oe;
  logic [31:0] reg_wdata = 32'h0, load_data = 32'h0, reg_rdata, d, v;
  logic [3:0]  tx_current_straps = 4'h0, deemphasis_straps = 4'h0;
  logic [3:0]  port0_driver_mode, port1_driver_mode, port2_driver_mode, port3_driver_mode;
  logic [1:0]  rx_termination_straps = 2'h0, tx_termination_straps = 2'h0;
  logic [13:0] ack_latency_value;
  logic [5:0]  power_parameter_value;
  logic [7:0]  ofs [9] = '{8'hB0, 8'hB4, 8'hB8, 8'hBC, 8'hC0, 8'hC4, 8'hC8, 8'hD8, 8'h10};
  logic [3:0]  codes [4] = '{vcgr_pkg::VCGR_MODE_RS232, vcgr_pkg::VCGR_MODE_RS422,
                            vcgr_pkg::VCGR_MODE_RS485_4W, vcgr_pkg::VCGR_MODE_RS485_2W};
  int          fail_count = 0, compares = 0;

  vcgr_regs uut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .load_valid,
    .load_addr, .load_data, .low_drive_strap, .high_drive_strap, .tx_current_straps, .deemphasis_straps,
    .rx_termination_straps, .tx_termination_straps, .pin_in, .pin_out, .pin_oe, .ack_latency_value,
    .ack_latency_user_en, .port0_driver_mode, .port1_driver_mode, .port2_driver_mode, .port3_driver_mode,
    .power_parameter_value);

  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Readable bits per offset; pin levels and straps are added by the caller
  function automatic logic [31:0] rw_mask(input logic [7:0] a);
    case (a)
      8'hB0:   return 32'h7FFF_0000;
      8'hB4:   return 32'hFFFF_FFFF;
      8'hB8:   return 32'h0000_003F;
      8'hD8:   return 32'h00FF_FF00;
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= w;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    r = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    void'($urandom(6998));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (ofs[i])
    begin
      rd(ofs[i], d);
      chk(d, 32'h0);
    end
    $display("reset values done");
    repeat (3) foreach (ofs[i])
    begin
      v = $urandom;
      wr(ofs[i], v);
      rd(ofs[i], d);
      chk(d, v & rw_mask(ofs[i]));
    end
    $display("read back done");
    foreach (codes[i])
    begin
      wr(8'hB4, {codes[i], 16'($urandom), {3{codes[i]}}});
      chk({16'h0, port3_driver_mode, port2_driver_mode, port1_driver_mode, port0_driver_mode},
          {16'h0, {4{codes[i]}}});
      v = $urandom;
      wr(8'hB0, v);
      chk({17'h0, ack_latency_user_en, ack_latency_value}, {17'h0, v[30:16]});
    end
    $display("driver and latency done");
    repeat (4)
    begin
      v = $urandom;
      @(posedge sys_clk);
      {tx_termination_straps, rx_termination_straps, deemphasis_straps, tx_current_straps,
       high_drive_strap, low_drive_strap} <= v[13:0];
      pin_in <= v[31:24];
      wr(8'hD8, v);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({16'h0, pin_oe, pin_out}, {16'h0, v[15:8], v[23:16] & v[15:8]});
      rd(8'hD8, d);
      chk(d, {8'h0, v[23:8], pin_in});
      rd(8'hC8, d);
      chk(d, {18'h0, v[13:0]});
    end
    $display("straps and pins done");
    foreach (ofs[i])
    begin
      if (ofs[i] == 8'hD8)
        continue;
      v = $urandom;
      @(posedge sys_clk);
      load_valid <= 1'b1;
      load_addr  <= ofs[i];
      load_data  <= v;
      @(posedge sys_clk);
      load_valid <= 1'b0;
      rd(ofs[i], d);
      chk(d, (ofs[i] == 8'hC8) ? {18'h0, v[13:0]} : v & rw_mask(ofs[i]));
      if (ofs[i] == 8'hB8)
        chk({26'h0, power_parameter_value}, {26'h0, v[5:0]});
    end
    $display("loader done");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    // Strap copy needs four edges to resettle after its stages clear
    repeat (4) @(posedge sys_clk);
    rd(8'hB4, d);
    chk(d, 32'h0);
    rd(8'hC8, d);
    chk(d, {18'h0, tx_termination_straps, rx_termination_straps, deemphasis_straps,
            tx_current_straps, high_drive_strap, low_drive_strap});
    $display("second reset done");
    wrap_up();
  end
endmodule
